// >>> src/irq_handler.sv
// Interrupt request handler with an AHB-Lite register slave.
// Function
// - CPU acknowledge fetches source number and priority level of the winner.
// - Acknowledge fetch clears the request bit of the returned source.
// - Software read of the information word clears the winner too; avoid it.
// - Stack pointer resets to zero; software loads it before interrupts.
// - Nonmaskable interrupt cannot be disabled; unused pin pulled high.
// - Nonmaskable pin reads back as an input-only bit of port eight.
// - Nonmaskable pin low forces the stop bit to zero, refusing stop.
// - Wait with nonmaskable pin low halts CPU, oscillator keeps running.
// - Polarity change may set the request; software clears it after.
// - Rewriting a control register keeps a simultaneous request.
`timescale 1ns/1ps
`default_nettype none
`include "irq_params.svh"

module irq_handler (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Pins
	input wire logic nmi_n,
	input wire logic [`NUM_EXT-1:0] external_irq_pins,
	// Internal sources, one-cycle events
	input wire logic [`NUM_INT-1:0] internal_irq,
	// CPU core
	input wire logic ack_strobe,
	input wire logic nmi_ack,
	output logic ack_valid,
	output logic [7:0] ack_info,
	output logic irq_req,
	output irq_pkg::level_t irq_level,
	output logic nmi_req,
	output logic [15:0] stack_pointer,
	// Power control
	output logic stop_mode,
	output logic cpu_halt,
	output logic osc_run
);

	localparam int NSRC = `NUM_SRC;
	localparam int NEXT = `NUM_EXT;
	localparam logic [7:0] CTRL_BASE = `OFF_CTRL_BASE;
	localparam logic [7:0] INFO_OFF = `OFF_INFO;
	localparam logic [7:0] PORT8_OFF = `OFF_PORT8;
	localparam logic [7:0] POWER_OFF = `OFF_POWER;
	localparam logic [7:0] SP_OFF = `OFF_SP;
	localparam logic [7:0] FLAGS_OFF = `OFF_FLAGS;

	// Synchronised pins.
	logic nmi_s;
	logic [NEXT-1:0] ext_s;
	logic nmi_prev;

	// Bus state.
	irq_pkg::read_phase_t rd_phase;
	logic [5:0] rd_idx;
	logic wr_pend;
	logic [5:0] wr_idx;
	logic addr_take;
	logic [31:0] rd_mux;

	// Software visible state.
	logic stop_mode_control_bit;
	logic wait_bit;
	logic global_enable;

	// Per-source state.
	logic [7:0] ctrl_rd [NSRC];
	logic [NSRC-1:0] slot_req;
	irq_pkg::level_t slot_level [NSRC];
	logic [NSRC-1:0] slot_clr;
	logic [NSRC-1:0] slot_we;
	logic [NSRC-1:0] slot_src;

	// Arbitration.
	irq_pkg::level_t best_level;
	irq_pkg::src_t best_src;
	logic found;
	logic [7:0] info_word;
	logic info_read;
	logic take_clear;

	// Decodes.
	logic wr_power;
	logic wr_sp;
	logic wr_flags;
	logic wr_ctrl;
	logic rd_ctrl;
	logic nmi_low;
	logic nmi_fall;
	logic wake;
	logic next_stop;
	logic next_wait;

	sync2 #(
		.WIDTH(NEXT + 1),
		.INIT('1)
	) u_pin_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in({nmi_n, external_irq_pins}),
		.sync_out({nmi_s, ext_s})
	);

	assign slot_src = {internal_irq, ext_s};

	genvar g;
	generate
		for (g = 0; g < NSRC; g++)
		begin : g_slot
			irq_slot #(
				.EXTERNAL(g < NEXT)
			) u_slot (
				.hclk(hclk),
				.hresetn(hresetn),
				.src_in(slot_src[g]),
				.ctrl_we(slot_we[g]),
				.ctrl_wdata(hwdata[7:0]),
				.req_clr(slot_clr[g]),
				.ctrl_rd(ctrl_rd[g]),
				.req(slot_req[g]),
				.level(slot_level[g])
			);
		end
	endgenerate

	// Strictly greater keeps the lowest index on a tie; level zero means
	// the source is disabled and can never win.
	always_comb
	begin
		best_level = '0;
		best_src = '0;
		for (int i = 0; i < NSRC; i++)
		begin
			if (slot_req[i] && (slot_level[i] > best_level))
			begin
				best_level = slot_level[i];
				best_src = irq_pkg::src_t'(i);
			end
		end
	end

	assign found = (best_level != '0);
	assign info_word = {found, best_level, 1'b0, best_src};

	// Bus decode. Reads take one wait state so the read data is built
	// after any write that was in its data phase.
	assign addr_take = hsel & hready & htrans[1];
	assign info_read = (rd_phase == irq_pkg::PH_READ)
		&& (rd_idx == INFO_OFF[7:2]);
	assign take_clear = ack_strobe | info_read;
	assign slot_clr = (take_clear && found)
		? (NSRC'(1) << best_src) : '0;

	assign wr_ctrl = wr_pend && (wr_idx[5:3] == CTRL_BASE[7:5]);
	assign slot_we = wr_ctrl ? (NSRC'(1) << wr_idx[2:0]) : '0;
	assign wr_power = wr_pend && (wr_idx == POWER_OFF[7:2]);
	assign wr_sp = wr_pend && (wr_idx == SP_OFF[7:2]);
	assign wr_flags = wr_pend && (wr_idx == FLAGS_OFF[7:2]);
	assign rd_ctrl = (rd_idx[5:3] == CTRL_BASE[7:5]);

	assign rd_mux =
		(rd_idx == INFO_OFF[7:2]) ? {24'h000000, info_word} :
		(rd_idx == PORT8_OFF[7:2]) ?
			(32'(nmi_s) << `PORT8_NMI_BIT) :
		(rd_idx == POWER_OFF[7:2]) ?
			{30'h00000000, wait_bit, stop_mode_control_bit} :
		(rd_idx == SP_OFF[7:2]) ? {16'h0000, stack_pointer} :
		(rd_idx == FLAGS_OFF[7:2]) ? {31'h00000000, global_enable} :
		rd_ctrl ? {24'h000000, ctrl_rd[rd_idx[2:0]]} :
		32'h00000000;

	// Nonmaskable input: a falling edge always raises the request; there
	// is no enable anywhere on this path.
	assign nmi_low = ~nmi_s;
	assign nmi_fall = nmi_prev & ~nmi_s;

	// A request at a nonzero level, or nmi_req, brings the core out of stop or wait. While the pin is
	// low the stop bit is held at zero and a write of one is refused;
	// wait is still allowed and the oscillator keeps running in it.
	assign wake = found | nmi_req;
	assign next_stop = nmi_low ? 1'b0 :
		wake ? 1'b0 :
		wr_power ? hwdata[`POWER_STOP_BIT] : stop_mode_control_bit;
	assign next_wait = wake ? 1'b0 :
		wr_power ? hwdata[`POWER_WAIT_BIT] : wait_bit;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rd_phase <= irq_pkg::PH_FREE;
			rd_idx <= '0;
			wr_pend <= 1'b0;
			wr_idx <= '0;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			wr_pend <= addr_take & hwrite;
			if (addr_take)
			begin
				wr_idx <= haddr[7:2];
				rd_idx <= haddr[7:2];
			end
			unique case (rd_phase)
				irq_pkg::PH_FREE:
				begin
					if (addr_take && !hwrite)
					begin
						rd_phase <= irq_pkg::PH_READ;
						hreadyout <= 1'b0;
					end
				end
				irq_pkg::PH_READ:
				begin
					rd_phase <= irq_pkg::PH_FREE;
					hrdata <= rd_mux;
					hreadyout <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			stack_pointer <= `SP_RESET;
			global_enable <= 1'b0;
			stop_mode_control_bit <= 1'b0;
			wait_bit <= 1'b0;
			stop_mode <= 1'b0;
			cpu_halt <= 1'b0;
			osc_run <= 1'b1;
		end
		else
		begin
			if (wr_sp)
				stack_pointer <= hwdata[15:0];
			if (wr_flags)
				global_enable <= hwdata[`FLAGS_GIE_BIT];
			stop_mode_control_bit <= next_stop;
			wait_bit <= next_wait;
			stop_mode <= next_stop;
			cpu_halt <= next_stop | next_wait;
			osc_run <= ~next_stop;
		end
	end

	// The first instruction after reset is protected by global_enable, which
	// resets to zero and masks irq_req until software sets it; nmi_req is not masked.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			nmi_prev <= 1'b1;
			nmi_req <= 1'b0;
			ack_valid <= 1'b0;
			ack_info <= 8'h00;
			irq_req <= 1'b0;
			irq_level <= '0;
		end
		else
		begin
			nmi_prev <= nmi_s;
			nmi_req <= nmi_fall | (nmi_req & ~nmi_ack);
			ack_valid <= ack_strobe;
			if (ack_strobe)
				ack_info <= info_word;
			irq_req <= found & global_enable;
			irq_level <= best_level;
		end
	end

endmodule : irq_handler

`default_nettype wire

// >>> src/irq_params.svh
// Register offsets, field positions and reset values of the interrupt block.
`ifndef IRQ_PARAMS_SVH
`define IRQ_PARAMS_SVH

`define NUM_SRC 8
`define NUM_EXT 6
`define NUM_INT 2

`define OFF_INFO 8'h00
`define OFF_PORT8 8'h04
`define OFF_POWER 8'h08
`define OFF_SP 8'h0C
`define OFF_FLAGS 8'h10
`define OFF_CTRL_BASE 8'h40

`define CTRL_LEVEL_LSB 0
`define CTRL_REQ_BIT 3
`define CTRL_POL_BIT 4

`define INFO_SRC_LSB 0
`define INFO_LEVEL_LSB 4
`define INFO_VALID_BIT 7

`define PORT8_NMI_BIT 5
`define POWER_STOP_BIT 0
`define POWER_WAIT_BIT 1
`define FLAGS_GIE_BIT 0

`define SP_RESET 16'h0000
`define LEVEL_RESET 3'h0
`define POL_RESET 1'b0

`endif

// >>> src/irq_pkg.sv
// Shared types of the interrupt block.
package irq_pkg;

	typedef logic [2:0] level_t;
	typedef logic [2:0] src_t;
	typedef enum logic {PH_FREE, PH_READ} read_phase_t;

endpackage : irq_pkg

// >>> src/irq_slot.sv
// One interrupt source: its control register and its request bit.
`timescale 1ns/1ps
`default_nettype none
`include "irq_params.svh"

module irq_slot #(
	parameter bit EXTERNAL = 1'b1
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Source: synchronised pin level, or a one-cycle internal event
	input wire logic src_in,
	// Software access
	input wire logic ctrl_we,
	input wire logic [7:0] ctrl_wdata,
	input wire logic req_clr,
	// State
	output logic [7:0] ctrl_rd,
	output logic req,
	output irq_pkg::level_t level
);

	logic pol;
	logic prev_active;
	logic active;
	logic event_hit;
	logic sw_keep;
	logic next_req;

	// Active state follows the programmed polarity, so a polarity flip that
	// makes an external source active is an edge and sets the request; software clears it afterwards.
	assign active = pol ? src_in : ~src_in;
	assign event_hit = EXTERNAL ? (active & ~prev_active) : src_in;

	// Writing a zero to the request bit only clears when no event lands
	// in that cycle, so a rewrite never loses a simultaneous request.
	assign sw_keep = ~(ctrl_we & ~ctrl_wdata[`CTRL_REQ_BIT]);
	assign next_req = event_hit
		| (req & ~req_clr & sw_keep)
		| (ctrl_we & ctrl_wdata[`CTRL_REQ_BIT]);

	assign ctrl_rd = {3'h0, pol, req, level};

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			level <= `LEVEL_RESET;
			pol <= `POL_RESET;
			req <= 1'b0;
			prev_active <= 1'b0;
		end
		else
		begin
			req <= next_req;
			prev_active <= active;
			if (ctrl_we)
			begin
				level <= ctrl_wdata[`CTRL_LEVEL_LSB +: 3];
				pol <= EXTERNAL ? ctrl_wdata[`CTRL_POL_BIT] : 1'b0;
			end
		end
	end

endmodule : irq_slot

`default_nettype wire

// >>> src/sync2.sv
// Two flip-flop synchroniser for a group of pin levels.
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '1
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			stage1 <= INIT;
			sync_out <= INIT;
		end
		else
		begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end

endmodule : sync2

`default_nettype wire

// >>> verification/interrupt_request_handling_tb_top.sv
// Register-level testbench of the interrupt handler.
`timescale 1ns/1ps
`default_nettype none

module interrupt_request_handling_tb_top;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rd;
	logic hreadyout, hresp, nmi_n, ack_valid, irq_req, nmi_req;
	logic stop_mode, cpu_halt, osc_run;
	logic [5:0] ext_want = 6'h3F;
	logic [5:0] pins;
	logic nmi_want = 1'b0;
	logic [1:0] internal_irq = 2'h0;
	logic ack_strobe = 1'b0;
	logic nmi_ack = 1'b0;
	logic [7:0] ack_info;
	irq_pkg::level_t irq_level;
	logic [15:0] stack_pointer;
	int error_cnt = 0;
	int comparisons = 0;

	always #4 hclk = ~hclk;

	irq_pin_model pin_u (.hclk(hclk), .ext_want(ext_want),
		.nmi_want(nmi_want), .external_irq_pins(pins), .nmi_n(nmi_n));

	irq_handler dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .nmi_n(nmi_n),
		.external_irq_pins(pins), .internal_irq(internal_irq),
		.ack_strobe(ack_strobe), .nmi_ack(nmi_ack), .ack_valid(ack_valid),
		.ack_info(ack_info), .irq_req(irq_req), .irq_level(irq_level),
		.nmi_req(nmi_req), .stack_pointer(stack_pointer),
		.stop_mode(stop_mode), .cpu_halt(cpu_halt), .osc_run(osc_run));

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// An internal event may ride on the data phase, to meet a write there.
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [1:0] ev);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		internal_irq <= ev;
		do
		begin
			@(posedge hclk);
			internal_irq <= 2'h0;
		end
		while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 2'h0);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, 2'h0);
		chk(rd, exp);
	endtask : rdc

	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask : tick

	// Pulses the nonmaskable clear when nmi is set, else the acknowledge.
	task automatic pulse(input logic nmi);
		@(posedge hclk);
		if (nmi)
			nmi_ack <= 1'b1;
		else
			ack_strobe <= 1'b1;
		@(posedge hclk);
		nmi_ack <= 1'b0;
		ack_strobe <= 1'b0;
		#1;
	endtask : pulse

	initial
	begin
		#100000;
		error_cnt++;
		report_and_stop();
	end

	initial
	begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		tick(3);
		rdc(8'h0C, 32'h0);
		rdc(8'h04, 32'h20);
		rdc(8'h80, 32'h0);
		wr(8'h08, 32'h1);
		rdc(8'h08, 32'h1);
		chk({stop_mode, cpu_halt, osc_run}, 32'h6);
		chk(hresp, 32'h0);
		wr(8'h08, 32'h0);
		$display("test 1 done");
		wr(8'h10, 32'h0);
		wr(8'h40, 32'h0A);
		wr(8'h4C, 32'h0D);
		bus(1'b0, 8'h04, 32'h0, 2'h0);
		wr(8'h10, 32'h1);
		tick(2);
		chk(irq_level, 32'h5);
		chk(irq_req, 32'h1);
		pulse(1'b0);
		chk(ack_info, 32'hD3);
		chk(ack_valid, 32'h1);
		rdc(8'h4C, 32'h05);
		tick(1);
		chk(irq_level, 32'h2);
		rdc(8'h00, 32'hA0);
		rdc(8'h40, 32'h02);
		pulse(1'b0);
		chk(ack_info[7], 32'h0);
		$display("test 2 done");
		wr(8'h44, 32'h03);
		@(posedge hclk);
		ext_want <= 6'h3D;
		tick(45);
		rdc(8'h44, 32'h0B);
		@(posedge hclk);
		ext_want <= 6'h3F;
		tick(45);
		wr(8'h44, 32'h03);
		wr(8'h44, 32'h13);
		tick(4);
		rdc(8'h44, 32'h1B);
		wr(8'h44, 32'h13);
		rdc(8'h44, 32'h13);
		bus(1'b1, 8'h58, 32'h01, 2'h1);
		rdc(8'h58, 32'h09);
		bus(1'b1, 8'h5C, 32'h0, 2'h2);
		rdc(8'h5C, 32'h08);
		$display("test 3 done");
		wr(8'h58, 32'h01);
		wr(8'h44, 32'h03);
		@(posedge hclk);
		nmi_want <= 1'b1;
		tick(5);
		chk(nmi_req, 32'h1);
		rdc(8'h04, 32'h0);
		pulse(1'b1);
		chk(nmi_req, 32'h0);
		wr(8'h08, 32'h1);
		rdc(8'h08, 32'h0);
		wr(8'h08, 32'h2);
		tick(2);
		chk({cpu_halt, osc_run}, 32'h3);
		bus(1'b1, 8'h04, 32'h0, 2'h1);
		tick(4);
		chk(cpu_halt, 32'h0);
		@(posedge hclk);
		nmi_want <= 1'b0;
		tick(5);
		rdc(8'h04, 32'h20);
		$display("test 4 done");
		report_and_stop();
	end
endmodule : interrupt_request_handling_tb_top

`default_nettype wire

// >>> verification/irq_handler_checker.sv
// Concurrent checks on the ports of the interrupt handler.
`timescale 1ns/1ps
`default_nettype none

module irq_handler_checker (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Pins and CPU side
	input wire logic nmi_n,
	input wire logic ack_strobe,
	input wire logic ack_valid,
	input wire logic [7:0] ack_info,
	input wire logic irq_req,
	input wire irq_pkg::level_t irq_level,
	input wire logic nmi_req,
	input wire logic [15:0] stack_pointer,
	// Power control
	input wire logic stop_mode,
	input wire logic cpu_halt,
	input wire logic osc_run
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	property p_ack_answer;
		ack_strobe |=> ack_valid;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("no ack answer");
	property p_ack_quiet;
		!ack_strobe |=> !ack_valid;
	endproperty
	a_ack_quiet: assert property (p_ack_quiet) else $error("stray ack");
	property p_ack_level;
		ack_valid && ack_info[7] |-> ack_info[6:4] != 3'h0;
	endproperty
	a_ack_level: assert property (p_ack_level) else $error("ack level 0");
	property p_req_level;
		irq_req |-> irq_level != 3'h0;
	endproperty
	a_req_level: assert property (p_req_level) else $error("req level 0");
	property p_sp_reset;
		$rose(hresetn) |-> stack_pointer == 16'h0000;
	endproperty
	a_sp_reset: assert property (p_sp_reset) else $error("sp not zero");
	property p_nmi_fire;
		$fell(nmi_n) ##1 !nmi_n |-> ##[1:3] nmi_req;
	endproperty
	a_nmi_fire: assert property (p_nmi_fire) else $error("nmi missed");
	property p_stop_refused;
		!nmi_n [*3] |=> !stop_mode;
	endproperty
	a_stop_refused: assert property (p_stop_refused) else $error("stop kept");
	property p_osc;
		osc_run == !stop_mode;
	endproperty
	a_osc: assert property (p_osc) else $error("osc state wrong");
	property p_stop_halts;
		$rose(stop_mode) |-> ##[0:1] cpu_halt;
	endproperty
	a_stop_halts: assert property (p_stop_halts) else $error("no halt");
	property p_nmi_wakes;
		nmi_req |=> !cpu_halt;
	endproperty
	a_nmi_wakes: assert property (p_nmi_wakes) else $error("no wake");
endmodule : irq_handler_checker

bind irq_handler irq_handler_checker chk_u (
	.hclk(hclk),
	.hresetn(hresetn),
	.nmi_n(nmi_n),
	.ack_strobe(ack_strobe),
	.ack_valid(ack_valid),
	.ack_info(ack_info),
	.irq_req(irq_req),
	.irq_level(irq_level),
	.nmi_req(nmi_req),
	.stack_pointer(stack_pointer),
	.stop_mode(stop_mode),
	.cpu_halt(cpu_halt),
	.osc_run(osc_run)
);

`default_nettype wire

// >>> verification/irq_pin_model.sv
// Behavioural model of the pins that feed the handler.
`timescale 1ns/1ps
`default_nettype none

module irq_pin_model (
	// Clock
	input wire logic hclk,
	// Wanted levels
	input wire logic [5:0] ext_want,
	input wire logic nmi_want,
	// Pins
	output logic [5:0] external_irq_pins,
	output logic nmi_n
);
	// A level shorter than 250 ns is never sent on the external pins, so their changes are delayed; nmi_n follows nmi_want without a hold.
	int unsigned held = 0;

	// One process drives the pins, so each has a single driver.
	initial
	begin
		external_irq_pins = 6'h3F;
		nmi_n = 1'b1;
		forever
		begin
			@(posedge hclk);
			held <= held + 1;
			if (ext_want != external_irq_pins && held >= 32)
			begin
				external_irq_pins <= ext_want;
				held <= 0;
			end
			nmi_n <= !nmi_want;
		end
	end
endmodule : irq_pin_model

`default_nettype wire
